// ===== rtl/tra_pkg.sv
// Purpose: constants and types for the terminal register channel
// Assumes: one 8-bit control byte and one 16-bit word per process data frame
// What this block does
// - Control bit 7 set marks the frame as a register access.
// - Control bit 6: one writes a register, zero reads it.
// - Control bits 5..0 hold the 6-bit register number.
// - Output data word is ignored during a read.
// - Read acknowledge: status byte equals control byte.
// - Write acknowledge: status byte equals control byte with bit 6 cleared.
// - Read returns the register value, high byte first.
// - Register 9 returns firmware version as two ASCII codes, first high.
// - User registers are write protected except code-word register 31.
// - Writing the unlock value to register 31 lifts the protection.
// - Any other value written to register 31 restores the protection.
// - New user register values take effect only after a restart.
// - Register 31 reads back the value last written to it.
// - Unlocked write to register 32 stores feature configuration, reads back unchanged.
// - Code-word register clears on every restart.
// - User register writes without prior unlock are discarded.
package tra_pkg;
    localparam int          CTRL_W      = 8;
    localparam int          DATA_W      = 16;
    localparam int          REGNUM_W    = 6;
    localparam int          BIT_REGMODE = 7;
    localparam int          BIT_WRITE   = 6;
    localparam logic [5:0]  REG_FWREV   = 6'h09;
    localparam logic [5:0]  REG_UNLOCK  = 6'h1f;
    localparam logic [5:0]  REG_FEATURE = 6'h20;
    localparam logic [15:0] UNLOCK_CODE = 16'h1235;
    localparam logic [15:0] UNLOCK_RST  = 16'h0000;
    localparam logic [15:0] FEATURE_RST = 16'h0000;
    localparam logic [7:0]  STATUS_RST  = 8'h00;
    localparam logic [15:0] RDWORD_RST  = 16'h0000;

    typedef struct packed {
        logic       regMode;
        logic       write;
        logic [5:0] regNum;
    } tra_ctrl_s;
endpackage : tra_pkg

// ===== rtl/tra_store_reg.sv
// Purpose: one 16-bit stored register with a staged active copy
// Assumes: restart pulse marks a terminal restart
// Notes:   active copy only follows the stored value on restart
`timescale 1ns/1ps
module tra_store_reg
    import tra_pkg::*;
#(
    parameter logic [15:0] RST_VAL = 16'h0000
)(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // control
    input  wire logic        wrEn,
    input  wire logic [15:0] wrData,
    input  wire logic        restart,
    // values
    output logic      [15:0] stored,
    output logic      [15:0] active
);
    logic [15:0] next_stored;
    logic [15:0] next_active;

    always_comb
    begin
        next_stored = wrEn ? wrData : stored;
        next_active = restart ? stored : active;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stored <= RST_VAL;
            active <= RST_VAL;
        end
        else
        begin
            stored <= next_stored;
            active <= next_active;
        end
    end
endmodule : tra_store_reg

// ===== rtl/tra_register_access.sv
// Purpose: register channel multiplexed on the cyclic process data
// Assumes: control byte and output word valid every clock; host keeps its side
// Notes:   answer appears one clock after a new control byte
`timescale 1ns/1ps
module tra_register_access
    import tra_pkg::*;
#(
    parameter logic [15:0] FW_REVISION = 16'h3042  // arbitrary value
)(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // process data from the coupler
    input  wire logic [7:0]  ctrlByte,
    input  wire logic [15:0] hostWriteWord,
    input  wire logic        restart,
    // process data to the coupler
    output logic      [7:0]  statusByte,
    output logic      [15:0] deviceReadWord,
    // state
    output logic             unlocked,
    output logic      [15:0] featureActive
);
    tra_ctrl_s   ctrl;
    logic [7:0]  lastCtrl;
    logic        lastValid;
    logic [7:0]  next_lastCtrl;
    logic        next_lastValid;
    logic [7:0]  next_statusByte;
    logic [15:0] next_deviceReadWord;
    logic [15:0] unlockKey;
    logic [15:0] next_unlockKey;
    logic        next_unlocked;
    logic        newAccess;
    logic        featureWr;
    logic [15:0] featureStored;

    assign ctrl = tra_ctrl_s'(ctrlByte);
    // register access only on a fresh control byte with mode bit set
    assign newAccess = ctrl.regMode && (!lastValid || ctrlByte != lastCtrl);
    assign featureWr = newAccess && ctrl.write && ctrl.regNum == REG_FEATURE
                       && unlockKey == UNLOCK_CODE;

    tra_store_reg #(
        .RST_VAL (FEATURE_RST)
    ) u_feature (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .wrEn    (featureWr),
        .wrData  (hostWriteWord),
        .restart (restart),
        .stored  (featureStored),
        .active  (featureActive)
    );

    always_comb
    begin
        next_lastCtrl       = ctrlByte;
        next_lastValid      = 1'b1;
        next_statusByte     = statusByte;
        next_deviceReadWord = deviceReadWord;
        next_unlockKey      = unlockKey;
        if (newAccess)
        begin
            if (ctrl.write)
            begin
                next_statusByte = ctrlByte & ~(8'h01 << BIT_WRITE);
                if (ctrl.regNum == REG_UNLOCK)
                    next_unlockKey = hostWriteWord;
            end
            else
            begin
                next_statusByte = ctrlByte;
                case (ctrl.regNum)
                    REG_FWREV:   next_deviceReadWord = FW_REVISION;
                    REG_UNLOCK:  next_deviceReadWord = unlockKey;
                    REG_FEATURE: next_deviceReadWord = featureStored;
                    default:     next_deviceReadWord = RDWORD_RST;
                endcase
            end
        end
        else if (!ctrl.regMode)
            next_statusByte = STATUS_RST;
        if (restart)
            next_unlockKey = UNLOCK_RST;
        next_unlocked = next_unlockKey == UNLOCK_CODE;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lastCtrl       <= STATUS_RST;
            lastValid      <= 1'b0;
            statusByte     <= STATUS_RST;
            deviceReadWord <= RDWORD_RST;
            unlockKey      <= UNLOCK_RST;
            unlocked       <= 1'b0;
        end
        else
        begin
            lastCtrl       <= next_lastCtrl;
            lastValid      <= next_lastValid;
            statusByte     <= next_statusByte;
            deviceReadWord <= next_deviceReadWord;
            unlockKey      <= next_unlockKey;
            unlocked       <= next_unlocked;
        end
    end
endmodule : tra_register_access

// ===== tb/tra_register_access_props.sv
// Purpose: port checks of the register channel
// Assumes: one clock domain
// Notes: answers land one clock after a new control byte
`timescale 1ns/1ps
module tra_register_access_props
    import tra_pkg::*;
#(parameter logic [15:0] FW_REVISION = 16'h3042)(
    // watched ports
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic [7:0]  ctrlByte,
    input wire logic [15:0] hostWriteWord,
    input wire logic        restart,
    input wire logic [7:0]  statusByte,
    input wire logic [15:0] deviceReadWord,
    input wire logic        unlocked,
    input wire logic [15:0] featureActive
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_read_ack: assert property ($changed(ctrlByte) && ctrlByte[7:6] == 2'b10
        |=> statusByte == $past(ctrlByte)) else $error("read ack");
    a_write_ack: assert property ($changed(ctrlByte) && ctrlByte[7:6] == 2'b11
        |=> statusByte == ($past(ctrlByte) & 8'hbf)) else $error("write ack");
    a_idle_zero: assert property (!ctrlByte[7] |=> statusByte == 8'h00)
        else $error("idle status");
    a_fw_read: assert property ($changed(ctrlByte) && ctrlByte == 8'h89
        |=> deviceReadWord == FW_REVISION) else $error("fw read");
    a_key_unlock: assert property ($changed(ctrlByte) && ctrlByte == 8'hdf
        && hostWriteWord == UNLOCK_CODE && !restart |=> unlocked) else $error("unlock");
    a_key_relock: assert property ($changed(ctrlByte) && ctrlByte == 8'hdf
        && hostWriteWord != UNLOCK_CODE |=> !unlocked) else $error("relock");
    a_restart_lock: assert property (restart |=> !unlocked) else $error("restart");
    a_feat_hold: assert property (!restart |=> $stable(featureActive))
        else $error("feature moved");
    c_unlock: cover property ($rose(unlocked));
    c_restart: cover property (restart);
    c_fw: cover property (ctrlByte == 8'h89);
endmodule : tra_register_access_props
bind tra_register_access tra_register_access_props #(.FW_REVISION(FW_REVISION)) props_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .ctrlByte(ctrlByte), .hostWriteWord(hostWriteWord),
    .restart(restart), .statusByte(statusByte), .deviceReadWord(deviceReadWord),
    .unlocked(unlocked), .featureActive(featureActive));

// ===== tb/tra_coupler_model.sv
// Purpose: coupler side of the process data
// Assumes: answer stands from one clock after the take
// Notes: a zero byte precedes each request
`timescale 1ns/1ps
module tra_coupler_model
    import tra_pkg::*;
(
    // clock
    input  wire logic   clk_sys,
    // to device
    output logic [7:0]  ctrlByte,
    output logic [15:0] hostWriteWord,
    output logic        restart
);
    initial
    begin
        ctrlByte = 8'h00;
        hostWriteWord = 16'h0000;
        restart = 1'b0;
    end
    task automatic xfer(input logic [7:0] c, input logic [15:0] w);
        @(posedge clk_sys);
        ctrlByte <= 8'h00;
        hostWriteWord <= ~w;
        @(posedge clk_sys);
        ctrlByte <= c;
        hostWriteWord <= w;
        @(posedge clk_sys);
        hostWriteWord <= ~w;
        @(posedge clk_sys);
        #1;
    endtask : xfer
    task automatic pulse();
        @(posedge clk_sys);
        restart <= 1'b1;
        @(posedge clk_sys);
        restart <= 1'b0;
    endtask : pulse
endmodule : tra_coupler_model

// ===== tb/testbench.sv
// Purpose: self-checking bench of the register channel
// Assumes: coupler model paces every request
// Notes: reference keeps key, stored and active feature
`timescale 1ns/1ps
module testbench
    import tra_pkg::*;
;
    localparam logic [15:0] FW = 16'h3a5c; // arbitrary value
    logic        clk_sys, rst_n, restart, unlocked;
    logic [7:0]  ctrlByte, statusByte, c;
    logic [15:0] hostWriteWord, deviceReadWord, featureActive, w, key, feat, featAct;
    int          n_fail, checked, cycles;
    logic [7:0]  seq [12] = '{8'h89, 8'he0, 8'ha0, 8'hdf, 8'h9f, 8'he0, 8'ha0, 8'h81,
                              8'hdf, 8'h9f, 8'he0, 8'ha0};
    tra_register_access #(.FW_REVISION(FW)) tra_register_access_i (.clk_sys(clk_sys),
        .rst_n(rst_n), .ctrlByte(ctrlByte), .hostWriteWord(hostWriteWord), .restart(restart),
        .statusByte(statusByte), .deviceReadWord(deviceReadWord), .unlocked(unlocked),
        .featureActive(featureActive));
    tra_coupler_model tra_coupler_model_i (.clk_sys(clk_sys), .ctrlByte(ctrlByte),
        .hostWriteWord(hostWriteWord), .restart(restart));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial
    begin
        void'($urandom(32'hf5a9));
        rst_n = 1'b0;
        key = 16'h0000;
        feat = 16'h0000;
        featAct = 16'h0000;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int p = 0; p < 2; p++)
        begin
            foreach (seq[i])
            begin
                c = seq[i];
                w = (c == 8'hdf) ? (i < 8 ? UNLOCK_CODE : {1'b1, 15'($urandom)}) : 16'($urandom);
                tra_coupler_model_i.xfer(c, w);
                chk(16'(statusByte), 16'(c[6] ? c & 8'hbf : c));
                if (c[6] && c[5:0] == REG_UNLOCK)
                    key = w;
                else if (c[6] && c[5:0] == REG_FEATURE && key == UNLOCK_CODE)
                    feat = w;
                if (!c[6])
                    chk(deviceReadWord, c[5:0] == REG_FWREV ? FW : c[5:0] == REG_UNLOCK ? key :
                        c[5:0] == REG_FEATURE ? feat : 16'h0000);
                chk(16'(unlocked), 16'(key == UNLOCK_CODE));
                chk(featureActive, featAct);
            end
            tra_coupler_model_i.pulse();
            key = 16'h0000;
            featAct = feat;
            repeat (2) @(posedge clk_sys);
            #1;
            chk(16'(unlocked), 16'h0000);
            chk(featureActive, featAct);
        end
        tally_and_finish();
    end
endmodule : testbench
